// ==== cfrw_device.sv ====
// cfrw_device: configuration memory with frame-granular read and write
// assumes the host keeps the word counts and pad words of its side
`timescale 1ns/10ps
module cfrw_device #(
  parameter int unsigned ROWS   = cfrw_pkg::DEF_ROWS,
  parameter int unsigned FRAMES = cfrw_pkg::DEF_FRAMES
) (
  cfrw_if.device               link,
  input  wire logic            global_hold_high_n,
  input  wire logic [1:0]      readback_security_field,
  output logic                 logic_hold_q,
  output logic [31:0]          crc_q,
  output logic                 cfg_changed_q
);
  localparam int unsigned FL = cfrw_pkg::frame_words(ROWS);
  // one length for every column kind; bit layout inside a frame is the host's
  localparam int unsigned DW = FL - 1;
  localparam int unsigned MW = FRAMES * DW;

  // a ram row spans four tile rows, which keeps ram frames as long as the rest
  if (ROWS < 1 || ROWS % 4 != 0 || FRAMES < 1) begin : g_bad_geometry
    $error("cfrw_device: unsupported geometry");
  end

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_WRITE = 4'b0010,
    ST_READ  = 4'b0100,
    ST_ERR   = 4'b1000
  } cfrw_state_e;

  // stored words hold the frame exactly as on the link, lut bits already inverted
  logic [31:0]              mem [MW];
  logic [MW-1:0]            filled_q;
  cfrw_state_e              state_q;
  logic [cfrw_pkg::ADDR_W-1:0] frame_q;
  logic [cfrw_pkg::CNT_W-1:0]  left_q;
  logic [15:0]              word_q;
  logic                     pad_phase_q;
  logic                     rd_valid_q;
  logic [31:0]              rd_data_q;
  logic                     err_q;

  wire wr_ok = readback_security_field[1];
  wire rd_ok = readback_security_field[0];
  wire in_range = (32'(link.cmd_addr) + 32'(link.cmd_frames)) <= FRAMES;

  assign link.cmd_ready = (state_q == ST_IDLE);
  assign link.rd_valid  = rd_valid_q;
  assign link.rd_data   = rd_data_q;
  assign link.op_busy   = (state_q == ST_WRITE) || (state_q == ST_READ);
  assign link.op_error  = err_q;

  wire [31:0] cur_idx = 32'(frame_q) * DW + 32'(word_q);

  always_ff @(posedge link.sys_clk or negedge link.resetn) begin
    if (!link.resetn) begin
      state_q     <= ST_IDLE;
      frame_q     <= '0;
      left_q      <= '0;
      word_q      <= 16'h0000;
      pad_phase_q <= 1'b0;
      err_q       <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (link.cmd_valid) begin
            frame_q     <= link.cmd_addr;
            left_q      <= link.cmd_frames;
            word_q      <= 16'h0000;
            // reads start inside the leading pad frame
            pad_phase_q <= (link.cmd_op == cfrw_pkg::CFRW_OP_READ);
            err_q       <= 1'b0;
            if (link.cmd_frames == '0 || !in_range)
              state_q <= ST_ERR;
            else if (link.cmd_op == cfrw_pkg::CFRW_OP_WRITE && wr_ok)
              state_q <= ST_WRITE;
            else if (link.cmd_op == cfrw_pkg::CFRW_OP_READ && rd_ok)
              state_q <= ST_READ;
            else
              state_q <= ST_ERR;
          end
        end
        ST_WRITE: begin
          // data words, then pad word, frame after frame, then a pad frame
          if (link.wr_valid) begin
            if (word_q == 16'(FL - 1)) begin
              word_q <= 16'h0000;
              if (left_q == '0) begin
                state_q <= ST_IDLE;
              end else begin
                left_q  <= left_q - 1'b1;
                frame_q <= frame_q + 1'b1;
              end
            end else begin
              word_q <= word_q + 16'h0001;
            end
          end
        end
        ST_READ: begin
          if (word_q == 16'(FL - 1)) begin
            word_q <= 16'h0000;
            if (pad_phase_q) begin
              pad_phase_q <= 1'b0;
            end else begin
              frame_q <= frame_q + 1'b1;
              left_q  <= left_q - 1'b1;
              if (left_q == 1)
                state_q <= ST_IDLE;
            end
          end else begin
            word_q <= word_q + 16'h0001;
          end
        end
        ST_ERR: begin
          err_q   <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // write path: only data slots land in memory; pad words and flush frame dropped
  wire wr_data_slot = (state_q == ST_WRITE) && link.wr_valid && (left_q != '0)
                      && (word_q < 16'(DW));
  // a never written word holds no value; its filled bit makes it count as new
  wire word_new = !filled_q[cur_idx] || (mem[cur_idx] != link.wr_data);
  always_ff @(posedge link.sys_clk) begin
    if (wr_data_slot && word_new)
      mem[cur_idx] <= link.wr_data;
  end

  always_ff @(posedge link.sys_clk or negedge link.resetn) begin
    if (!link.resetn)
      filled_q <= '0;
    else if (wr_data_slot)
      filled_q[cur_idx] <= 1'b1;
  end

  always_ff @(posedge link.sys_clk or negedge link.resetn) begin
    if (!link.resetn)
      cfg_changed_q <= 1'b0;
    else if (wr_data_slot)
      cfg_changed_q <= word_new;
  end

  // read path: pad word leads each frame, data words follow
  always_ff @(posedge link.sys_clk or negedge link.resetn) begin
    if (!link.resetn) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= 32'h00000000;
    end else begin
      rd_valid_q <= (state_q == ST_READ);
      if (state_q != ST_READ || pad_phase_q || word_q == 16'h0000)
        rd_data_q <= cfrw_pkg::PAD_WORD;
      else
        rd_data_q <= mem[32'(frame_q) * DW + 32'(word_q) - 1];
    end
  end

  // checksum covers every word of an accepted write, pads included; readback words are not counted
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--)
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? 32'h04C11DB7 : 32'h00000000);
    crc_step = r;
  endfunction : crc_step

  always_ff @(posedge link.sys_clk or negedge link.resetn) begin
    if (!link.resetn)
      crc_q <= 32'h00000000;
    else if (state_q == ST_IDLE && link.cmd_valid)
      crc_q <= 32'h00000000;
    else if (state_q == ST_WRITE && link.wr_valid)
      crc_q <= crc_step(crc_q, link.wr_data);
  end

  always_ff @(posedge link.sys_clk or negedge link.resetn) begin
    if (!link.resetn)
      logic_hold_q <= 1'b1;
    else
      logic_hold_q <= !global_hold_high_n;
  end
endmodule : cfrw_device

// ==== cfrw_host.sv ====
// cfrw_host: issues frame commands and streams words with pads
// assumes the device answers reads one word per clock after the command
`timescale 1ns/10ps
module cfrw_host #(
  parameter int unsigned ROWS = cfrw_pkg::DEF_ROWS
) (
  cfrw_if.host                          link,
  input  wire logic                     req_valid,
  input  wire logic [1:0]               req_op,
  input  wire logic [1:0]               req_col,
  input  wire logic [cfrw_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [cfrw_pkg::CNT_W-1:0]  req_frames,
  input  wire logic [31:0]              user_wdata,
  output logic                          user_wtake_q,
  output logic                          user_rvalid_q,
  output logic [31:0]                   user_rdata_q,
  output logic                          done_q,
  output logic [31:0]                   crc_q
);
  localparam int unsigned FL = cfrw_pkg::frame_words(ROWS);
  if (ROWS < 1) begin : g_bad_geometry
    $error("cfrw_host: unsupported geometry");
  end

  logic              cmd_valid_q;
  logic              wr_valid_q;
  logic [31:0]       wr_data_q;
  logic              writing_q;
  logic [cfrw_pkg::CNT_W-1:0] left_q;
  logic [15:0]       word_q;
  logic              skip_q;
  // command fields held in flops so they stay put while the device takes them
  logic [1:0]        cmd_op_q;
  logic [1:0]        cmd_col_q;
  logic [cfrw_pkg::ADDR_W-1:0] cmd_addr_q;
  logic [cfrw_pkg::CNT_W-1:0]  cmd_frames_q;

  assign link.cmd_valid  = cmd_valid_q;
  assign link.cmd_op     = cmd_op_q;
  assign link.cmd_col    = cmd_col_q;
  assign link.cmd_addr   = cmd_addr_q;
  assign link.cmd_frames = cmd_frames_q;
  assign link.wr_valid   = wr_valid_q;
  assign link.wr_data    = wr_data_q;

  wire data_slot = writing_q && (left_q != '0) && (word_q < 16'(FL - 1));

  always_ff @(posedge link.sys_clk or negedge link.resetn) begin
    if (!link.resetn) begin
      cmd_valid_q  <= 1'b0;
      cmd_op_q     <= 2'h0;
      cmd_col_q    <= 2'h0;
      cmd_addr_q   <= '0;
      cmd_frames_q <= '0;
      writing_q    <= 1'b0;
      left_q       <= '0;
      word_q       <= 16'h0000;
      wr_valid_q   <= 1'b0;
      wr_data_q    <= 32'h00000000;
      user_wtake_q <= 1'b0;
      done_q       <= 1'b0;
    end else begin
      cmd_valid_q  <= 1'b0;
      done_q       <= 1'b0;
      wr_valid_q   <= 1'b0;
      user_wtake_q <= 1'b0;
      if (req_valid && link.cmd_ready && !cmd_valid_q && !writing_q) begin
        cmd_valid_q <= 1'b1;
        cmd_op_q     <= req_op;
        cmd_col_q    <= req_col;
        cmd_addr_q   <= req_addr;
        cmd_frames_q <= req_frames;
        writing_q   <= (req_op == cfrw_pkg::CFRW_OP_WRITE);
        left_q      <= req_frames;
        word_q      <= 16'h0000;
      end else if (writing_q) begin
        wr_valid_q   <= 1'b1;
        // full frame content from the user; pads are zeros
        wr_data_q    <= data_slot ? user_wdata : cfrw_pkg::PAD_WORD;
        user_wtake_q <= data_slot;
        if (word_q == 16'(FL - 1)) begin
          word_q <= 16'h0000;
          if (left_q == '0) begin
            writing_q <= 1'b0;
            done_q    <= 1'b1;
          end else begin
            left_q <= left_q - 1'b1;
          end
        end else begin
          word_q <= word_q + 16'h0001;
        end
      end
    end
  end

  // readback: drop pad frame and first pad word so data aligns to write format
  logic [15:0] skip_cnt_q;
  always_ff @(posedge link.sys_clk or negedge link.resetn) begin
    if (!link.resetn) begin
      skip_q        <= 1'b0;
      skip_cnt_q    <= 16'h0000;
      user_rvalid_q <= 1'b0;
      user_rdata_q  <= 32'h00000000;
    end else begin
      user_rvalid_q <= 1'b0;
      if (cmd_valid_q && cmd_op_q == cfrw_pkg::CFRW_OP_READ) begin
        skip_q     <= 1'b1;
        skip_cnt_q <= 16'h0000;
      end else if (link.rd_valid) begin
        if (skip_q) begin
          skip_cnt_q <= skip_cnt_q + 16'h0001;
          if (skip_cnt_q == 16'(FL)) skip_q <= 1'b0;
        end else begin
          user_rvalid_q <= 1'b1;
          user_rdata_q  <= link.rd_data;
        end
      end
    end
  end

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--)
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? 32'h04C11DB7 : 32'h00000000);
    crc_step = r;
  endfunction : crc_step

  always_ff @(posedge link.sys_clk or negedge link.resetn) begin
    if (!link.resetn)
      crc_q <= 32'h00000000;
    else if (cmd_valid_q)
      crc_q <= 32'h00000000;
    else if (wr_valid_q)
      crc_q <= crc_step(crc_q, wr_data_q);
  end
endmodule : cfrw_host

// ==== cfrw_if.sv ====
// cfrw_if: command and word stream between host and configuration memory
// assumes the testbench joins host and device modports on one clock
`timescale 1ns/10ps
interface cfrw_if #(
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned CNT_W  = 20
) (
  input wire logic sys_clk,
  input wire logic resetn
);
  logic              cmd_valid;
  logic [1:0]        cmd_op;
  logic [1:0]        cmd_col;
  logic [ADDR_W-1:0] cmd_addr;
  logic [CNT_W-1:0]  cmd_frames;
  logic              cmd_ready;
  logic              wr_valid;
  logic [31:0]       wr_data;
  logic              rd_valid;
  logic [31:0]       rd_data;
  logic              op_busy;
  logic              op_error;

  modport host (
    input  sys_clk, resetn, cmd_ready, rd_valid, rd_data, op_busy, op_error,
    output cmd_valid, cmd_op, cmd_col, cmd_addr, cmd_frames, wr_valid, wr_data
  );
  modport device (
    input  sys_clk, resetn, cmd_valid, cmd_op, cmd_col, cmd_addr, cmd_frames,
           wr_valid, wr_data,
    output cmd_ready, rd_valid, rd_data, op_busy, op_error
  );
endinterface : cfrw_if

// ==== cfrw_monitor.sv ====
// cfrw_monitor: timing and framing checks on the frame access link
// assumes both ends share sys_clk and pads travel as zero words
`timescale 1ns/10ps
module cfrw_monitor #(
  parameter int unsigned ROWS   = 4,
  parameter int unsigned FRAMES = 64
) (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        cmd_valid,
  input wire logic [1:0]  cmd_op,
  input wire logic [15:0] cmd_addr,
  input wire logic [19:0] cmd_frames,
  input wire logic        cmd_ready,
  input wire logic        wr_valid,
  input wire logic [31:0] wr_data,
  input wire logic        rd_valid,
  input wire logic [31:0] rd_data,
  input wire logic        op_busy,
  input wire logic        op_error
);
  localparam int unsigned FL = cfrw_pkg::frame_words(ROWS);
  logic [15:0] rrun_q;
  logic [15:0] wrun_q;
  logic        taken;
  assign taken = cmd_valid && cmd_ready;
  // run lengths let the pad positions be judged without lookahead
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rrun_q <= 16'h0;
    end else begin
      rrun_q <= rd_valid ? rrun_q + 16'h1 : 16'h0;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrun_q <= 16'h0;
    end else begin
      wrun_q <= wr_valid ? wrun_q + 16'h1 : 16'h0;
    end
  end
  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  read_answer_a: assert property (taken && cmd_op == 2'h2 |-> ##2 (rd_valid || op_error))
    else $error("read command got no answer");
  read_length_a: assert property ($fell(rd_valid) |-> rrun_q % FL == 0 && rrun_q >= 2 * FL)
    else $error("readback run not whole frames plus pad frame");
  pad_frame_a: assert property (rd_valid && rrun_q < FL |-> rd_data == 32'h00000000)
    else $error("leading pad frame carries data");
  pad_first_a: assert property (rd_valid && rrun_q % FL == 0 |-> rd_data == 32'h00000000)
    else $error("frame does not open with pad word");
  write_length_a: assert property ($fell(wr_valid) && !op_error |-> wrun_q % FL == 0
    && wrun_q >= 2 * FL)
    else $error("write run not whole frames plus pad frame");
  pad_last_a: assert property (wr_valid && wrun_q % FL == FL - 1 |-> wr_data == 32'h00000000)
    else $error("written frame does not end with pad word");
  zero_frames_a: assert property (taken && cmd_frames == 20'h0 |-> ##2 op_error)
    else $error("empty transfer not refused");
  frame_range_a: assert property (taken && 32'(cmd_addr) + 32'(cmd_frames) > FRAMES
    |-> ##2 op_error)
    else $error("transfer past last frame not refused");
  quiet_error_a: assert property (op_error |-> !rd_valid)
    else $error("data moved on a refused command");
  busy_read_a: assert property (rd_valid |-> $past(op_busy))
    else $error("readback word outside a busy operation");
endmodule : cfrw_monitor

// ==== cfrw_pkg.sv ====
// cfrw_pkg: shared constants and command codes for the frame access link
// assumes one configuration clock shared by both ends
package cfrw_pkg;
  localparam int unsigned ROW_BITS        = 18;
  localparam int unsigned WORD_BITS       = 32;
  localparam int unsigned RAM_ROW_BITS    = 72;
  localparam int unsigned LUT_FRAMES      = 16;
  localparam int unsigned DEF_ROWS        = 4;
  localparam int unsigned DEF_FRAMES      = 64;
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned CNT_W           = 20;
  localparam logic [1:0]  COL_LOGIC       = 2'h0;
  localparam logic [1:0]  COL_IO          = 2'h1;
  localparam logic [1:0]  COL_RAM         = 2'h2;
  localparam logic [31:0] PAD_WORD        = 32'h00000000;

  // frame length in words, pad word included
  function automatic int unsigned frame_words(input int unsigned rows);
    frame_words = (ROW_BITS * (rows + 2) + WORD_BITS - 1) / WORD_BITS + 1;
  endfunction : frame_words

  typedef enum logic [1:0] {
    CFRW_OP_WRITE = 2'h1,
    CFRW_OP_READ  = 2'h2
  } cfrw_op_e;
endpackage : cfrw_pkg

// ==== tb_top.sv ====
// tb_top: drives the host user side and device controls, reads back
// assumes ROWS 4 so a frame is five words, pad word included
`timescale 1ns/10ps
module tb_top;
  localparam int unsigned ROWS   = 4;
  localparam int unsigned FRAMES = 8;
  localparam int unsigned FL     = cfrw_pkg::frame_words(ROWS);
  logic                        sys_clk;
  logic                        resetn;
  logic                        req_valid;
  logic [1:0]                  req_op;
  logic [1:0]                  req_col;
  logic [cfrw_pkg::ADDR_W-1:0] req_addr;
  logic [cfrw_pkg::CNT_W-1:0]  req_frames;
  logic [31:0]                 user_wdata;
  logic                        user_wtake_q;
  logic                        user_rvalid_q;
  logic [31:0]                 user_rdata_q;
  logic [31:0]                 host_crc;
  logic                        global_hold_high_n;
  logic [1:0]                  readback_security_field;
  logic                        logic_hold_q;
  logic [31:0]                 dev_crc;
  logic                        cfg_changed_q;
  int                          n_mismatch;
  int                          checks_done;
  int                          wk;
  int                          rcnt;
  int                          wcnt;
  int                          ndone;
  logic                        host_done;
  logic [31:0]                 rq[$];
  logic [1:0]  bad_sec[4] = '{2'h2, 2'h1, 2'h3, 2'h3};
  logic [1:0]  bad_op[4] = '{2'h2, 2'h1, 2'h2, 2'h2};
  logic [15:0] bad_addr[4] = '{16'h0, 16'h0, 16'h0, 16'h7};
  logic [19:0] bad_frm[4] = '{20'h1, 20'h1, 20'h0, 20'h2};

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  cfrw_if #(.ADDR_W(cfrw_pkg::ADDR_W), .CNT_W(cfrw_pkg::CNT_W)) cfrw_if_i (
    .sys_clk(sys_clk), .resetn(resetn));
  cfrw_device #(.ROWS(ROWS), .FRAMES(FRAMES)) cfrw_device_i (.link(cfrw_if_i),
    .global_hold_high_n(global_hold_high_n), .readback_security_field(readback_security_field),
    .logic_hold_q(logic_hold_q), .crc_q(dev_crc), .cfg_changed_q(cfg_changed_q));
  cfrw_host #(.ROWS(ROWS)) cfrw_host_i (.link(cfrw_if_i), .req_valid(req_valid),
    .req_op(req_op), .req_col(req_col), .req_addr(req_addr), .req_frames(req_frames),
    .user_wdata(user_wdata), .user_wtake_q(user_wtake_q), .user_rvalid_q(user_rvalid_q),
    .user_rdata_q(user_rdata_q), .done_q(host_done), .crc_q(host_crc));
  cfrw_monitor #(.ROWS(ROWS), .FRAMES(FRAMES)) cfrw_monitor_i (.sys_clk(sys_clk),
    .resetn(resetn), .cmd_valid(cfrw_if_i.cmd_valid), .cmd_op(cfrw_if_i.cmd_op),
    .cmd_addr(cfrw_if_i.cmd_addr), .cmd_frames(cfrw_if_i.cmd_frames),
    .cmd_ready(cfrw_if_i.cmd_ready), .wr_valid(cfrw_if_i.wr_valid),
    .wr_data(cfrw_if_i.wr_data), .rd_valid(cfrw_if_i.rd_valid),
    .rd_data(cfrw_if_i.rd_data), .op_busy(cfrw_if_i.op_busy),
    .op_error(cfrw_if_i.op_error));

  // last word of a 108-bit frame holds 12 bits, the rest stays zero
  function automatic logic [31:0] wv(input int i);
    wv = (i % 4 == 3) ? {i[11:0], 20'h00000} : (32'hC0DE0000 | {16'h0, i[15:0]});
  endfunction : wv

  always @(posedge sys_clk) begin
    if (user_rvalid_q === 1'b1) rq.push_back(user_rdata_q);
    if (cfrw_if_i.rd_valid === 1'b1) rcnt++;
    if (cfrw_if_i.wr_valid === 1'b1) wcnt++;
    if (host_done === 1'b1) ndone++;
  end
  // next user word is offered as soon as the previous one is taken
  always @(negedge sys_clk) begin
    if (user_wtake_q === 1'b1) wk++;
    user_wdata = wv(wk);
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %08h expected %08h", $time, seen, exp);
    end
  endtask : check

  task automatic run_op(input logic [1:0] op, input logic [15:0] addr, input logic [19:0] frm);
    int n;
    @(posedge sys_clk);
    wk = 0;
    @(negedge sys_clk);
    rq.delete();
    rcnt = 0;
    wcnt = 0;
    ndone = 0;
    req_valid = 1'b1;
    req_op = op;
    req_addr = addr;
    req_frames = frm;
    n = 0;
    while (cfrw_if_i.cmd_valid !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    if (cfrw_if_i.cmd_valid !== 1'b1) begin
      n_mismatch++;
      summarize();
    end
    req_valid = 1'b0;
    repeat (3) @(negedge sys_clk);
    while ((cfrw_if_i.cmd_ready !== 1'b1 || cfrw_if_i.wr_valid === 1'b1) && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    if (cfrw_if_i.cmd_ready !== 1'b1 || cfrw_if_i.wr_valid === 1'b1) begin
      n_mismatch++;
      summarize();
    end
    repeat (4) @(negedge sys_clk);
  endtask : run_op

  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req_op = 2'h0;
    req_col = cfrw_pkg::COL_LOGIC;
    req_addr = 16'h0;
    req_frames = 20'h0;
    global_hold_high_n = 1'b1;
    readback_security_field = 2'h3;
    n_mismatch = 0;
    checks_done = 0;
    wk = 0;
    rcnt = 0;
    wcnt = 0;
    repeat (4) @(negedge sys_clk);
    resetn = 1'b1;
    run_op(2'h1, 16'h2, 20'h2);
    check(wcnt, 3 * FL);
    check(ndone, 1);
    check(host_crc, dev_crc);
    check({31'h0, cfg_changed_q}, 32'h1);
    $display("test write two frames done");
    run_op(2'h2, 16'h2, 20'h2);
    check(rcnt, 3 * FL);
    // only the first pad word is dropped, the second frame keeps its own
    check(rq.size(), 9);
    for (int i = 0; i < 9; i++)
      check(rq[i], (i == 4) ? cfrw_pkg::PAD_WORD : wv(i - i / 5));
    run_op(2'h2, 16'h3, 20'h1);
    for (int i = 0; i < 4; i++) check(rq[i], wv(4 + i));
    check(rq.size(), 4);
    check(rcnt, 2 * FL);
    $display("test readback done");
    run_op(2'h1, 16'h2, 20'h2);
    check({31'h0, cfg_changed_q}, 32'h0);
    check(host_crc, dev_crc);
    $display("test identical rewrite done");
    for (int i = 0; i < 4; i++) begin
      readback_security_field = bad_sec[i];
      run_op(bad_op[i], bad_addr[i], bad_frm[i]);
      check({31'h0, cfrw_if_i.op_error}, 32'h1);
      check(rcnt, 0);
    end
    $display("test refusals done");
    readback_security_field = 2'h3;
    global_hold_high_n = 1'b0;
    run_op(2'h2, 16'h2, 20'h1);
    check({31'h0, logic_hold_q}, 32'h1);
    for (int i = 0; i < 4; i++) check(rq[i], wv(i));
    global_hold_high_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    check({31'h0, logic_hold_q}, 32'h0);
    $display("test hold and live readback done");
    summarize();
  end
endmodule : tb_top
